// ### tc_params.svh
// Offsets, field positions, reset values and timing counts of the dual timer/counter
`ifndef TC_PARAMS_SVH
`define TC_PARAMS_SVH

`define TC_ADDR_W 4
`define TC_ADDR_MODE 4'h0
`define TC_ADDR_CTRL 4'h1
`define TC_ADDR_CLKCTL 4'h2
`define TC_ADDR_C0LO 4'h3
`define TC_ADDR_C0HI 4'h4
`define TC_ADDR_C1LO 4'h5
`define TC_ADDR_C1HI 4'h6
`define TC_ADDR_ISTAT 4'h7
`define TC_ADDR_IMASK 4'h8

`define TC_MODE_FIELD0_LSB 0
`define TC_MODE_FUNC0 2
`define TC_MODE_GATE0 3
`define TC_MODE_FIELD1_LSB 4
`define TC_MODE_FUNC1 6
`define TC_MODE_GATE1 7

`define TC_CTRL_RUN0 4
`define TC_CTRL_FLAG0 5
`define TC_CTRL_RUN1 6
`define TC_CTRL_FLAG1 7

`define TC_CLK_TURBO0 3
`define TC_CLK_TURBO1 4

`define TC_RST_BYTE 8'h00
`define TC_RST_IRQ 2'h0

`define TC_PHASE_THREE 2'h2
`define TC_PHASE_FOUR 2'h3

`define TC_CLK_PERIOD_NS 8
`define TC_CLKS_PER_MCYCLE 4
`define TC_STD_TICK_CLKS 12
`define TC_TURBO_TICK_CLKS 4
`define TC_STD_MCYCLES (`TC_STD_TICK_CLKS / `TC_CLKS_PER_MCYCLE)

`endif

// ### tc_pkg.sv
// Types shared by the dual timer/counter
`default_nettype none
package tc_pkg;
  typedef enum logic [1:0] {
    MODE_13BIT,
    MODE_16BIT,
    MODE_RELOAD8,
    MODE_SPLIT
  } cnt_mode_t;
  typedef logic [7:0] byte_t;
endpackage
`default_nettype wire

// ### dual_timer.sv
// Two 16-bit timer/counters with four modes, register port and interrupt
`default_nettype none
`include "tc_params.svh"

// Overview of operation
// R1: Timer function counts one tick per twelve clocks, or four with turbo select.
// R2: Reset clears both turbo select bits, giving the divide-by-twelve time base.
// R3: Count inputs sampled at phase four; high then low marks a falling edge.
// R4: Count registers change only at phase three; edges count next machine cycle.
// R5: External count sources must stay at or below one twenty-fourth of clock.
// R6: Mode register bit 2 picks counter 0 function, bit 6 counter 1.
// R7: Each counter has its own two-bit mode field selecting four modes.
// R8: Mode 0 is 13 bits: high byte plus low five bits of low byte.
// R9: Mode 0 high byte steps on prescale wrap; 1FFF wraps to 0 and flags.
// R10: Counting needs run bit and either gate clear or interrupt pin high.
// R11: Mode 1 uses all 16 bits; FFFF to 0000 sets the overflow flag.
// R12: Mode 2 low byte wraps FF to 00, flags, reloads from unchanged high byte.
// R13: Counter 1 in mode 3 holds its count frozen.
// R14: Counter 0 mode 3 low byte keeps counter 0 controls, flag and function.
// R15: Counter 0 mode 3 high byte counts ticks, run by counter 1 run bit.
// R16: Counter 1 then runs without run bit or flag; mode 3 stops it.
// R17: Overflow flags set at phase three of the overflowing machine cycle.
// R18: Vectoring to a counter's service routine clears its overflow flag.
// R19: Software writes load count bytes directly; counting resumes from them.
module dual_timer
  import tc_pkg::*;
#(
  parameter int STD_DIV = `TC_STD_TICK_CLKS
) (
  input wire logic CLK_I,      // System clock, 125 MHz
  input wire logic RESET_I,    // Synchronous reset, active high
  input wire logic [3:0] ADDR_I, // Register address
  input wire logic [7:0] WDATA_I, // Register write data
  input wire logic WE_I,       // Write strobe
  input wire logic RE_I,       // Read strobe
  input wire logic CNT0_PIN_I, // Counter 0 count input pin
  input wire logic CNT1_PIN_I, // Counter 1 count input pin
  input wire logic EXT_EXTERNAL_INTERRUPT0_PIN_PIN_I, // External interrupt 0 pin, gate for counter 0
  input wire logic EXT_EXTERNAL_INTERRUPT1_PIN_PIN_I, // External interrupt 1 pin, gate for counter 1
  input wire logic VECTOR0_I,  // Processor vectors to counter 0 service routine
  input wire logic VECTOR1_I,  // Processor vectors to counter 1 service routine
  output logic [7:0] RDATA_O,  // Read data, valid the cycle after RE_I
  output logic OVF0_O,         // Counter 0 overflow flag
  output logic OVF1_O,         // Counter 1 overflow flag
  output logic IRQ_O           // Interrupt, high while an unmasked status bit is set
);

  localparam int STD_MC = STD_DIV / `TC_CLKS_PER_MCYCLE;
  localparam logic [1:0] DIV_LAST = 2'(STD_MC - 1);

  initial begin
    if (STD_DIV % `TC_CLKS_PER_MCYCLE != 0 || STD_MC < 1 || STD_MC > 4) begin
      $error("STD_DIV must be 4, 8, 12 or 16");
    end
  end

  // Next count for a counter: {overflow, high byte, low byte}
  function automatic logic [16:0] bump(input cnt_mode_t m, input byte_t th, input byte_t tl);
    logic [13:0] c13;
    logic [16:0] c16;
    logic [8:0] c8;
    c13 = {1'b0, th, tl[4:0]} + 14'h0001;
    c16 = {1'b0, th, tl} + 17'h00001;
    c8 = {1'b0, tl} + 9'h001;
    case (m)
      MODE_13BIT: bump = {c13[13], c13[12:5], tl[7:5], c13[4:0]}; // R8 R9
      MODE_16BIT: bump = c16; // R11
      MODE_RELOAD8: bump = {c8[8], th, c8[8] ? th : c8[7:0]}; // R12
      default: bump = {c8[8], th, c8[7:0]}; // R14
    endcase
  endfunction

  // Machine cycle phase and pin synchronisers
  logic [1:0] phase_q;
  logic [3:0] pin_s1_q;
  logic [3:0] pin_s2_q;
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      phase_q <= 2'h0;
      pin_s1_q <= 4'h0;
      pin_s2_q <= 4'h0;
    end else begin
      phase_q <= phase_q + 2'h1;
      pin_s1_q <= {EXT_EXTERNAL_INTERRUPT1_PIN_PIN_I, EXT_EXTERNAL_INTERRUPT0_PIN_PIN_I, CNT1_PIN_I, CNT0_PIN_I};
      pin_s2_q <= pin_s1_q;
    end
  end

  wire at_c3 = (phase_q == `TC_PHASE_THREE);
  wire at_c4 = (phase_q == `TC_PHASE_FOUR);
  wire cnt0_s = pin_s2_q[0];
  wire cnt1_s = pin_s2_q[1];
  wire external_interrupt0_pin_s = pin_s2_q[2];
  wire external_interrupt1_pin_s = pin_s2_q[3];

  // Software registers
  byte_t mode_q, ctrl_q, clkctl_q, th0_q, tl0_q, th1_q, tl1_q;
  byte_t th0_d, tl0_d, th1_d, tl1_d;
  logic [1:0] stat_q, mask_q, stat_d, mask_d;
  logic ovf0_q, ovf1_q, ovf0_d, ovf1_d, irq_q;
  byte_t rdata_q;

  wire wr_mode = WE_I && ADDR_I == `TC_ADDR_MODE;
  wire wr_ctrl = WE_I && ADDR_I == `TC_ADDR_CTRL;
  wire wr_clk = WE_I && ADDR_I == `TC_ADDR_CLKCTL;
  wire wr_tl0 = WE_I && ADDR_I == `TC_ADDR_C0LO;
  wire wr_th0 = WE_I && ADDR_I == `TC_ADDR_C0HI;
  wire wr_tl1 = WE_I && ADDR_I == `TC_ADDR_C1LO;
  wire wr_th1 = WE_I && ADDR_I == `TC_ADDR_C1HI;
  wire wr_stat = WE_I && ADDR_I == `TC_ADDR_ISTAT;
  wire wr_mask = WE_I && ADDR_I == `TC_ADDR_IMASK;

  wire cnt_mode_t m0 = cnt_mode_t'(mode_q[`TC_MODE_FIELD0_LSB +: 2]); // R7
  wire cnt_mode_t m1 = cnt_mode_t'(mode_q[`TC_MODE_FIELD1_LSB +: 2]); // R7
  wire func0 = mode_q[`TC_MODE_FUNC0]; // R6
  wire func1 = mode_q[`TC_MODE_FUNC1]; // R6
  wire gate0 = mode_q[`TC_MODE_GATE0];
  wire gate1 = mode_q[`TC_MODE_GATE1];
  wire run0 = ctrl_q[`TC_CTRL_RUN0];
  wire run1 = ctrl_q[`TC_CTRL_RUN1];
  wire turbo0 = clkctl_q[`TC_CLK_TURBO0];
  wire turbo1 = clkctl_q[`TC_CLK_TURBO1];
  wire split0 = (m0 == MODE_SPLIT);

  // Time base: one tick per machine cycle in turbo, else one per STD_MC cycles
  logic [1:0] div0_q, div1_q;
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      div0_q <= 2'h0;
      div1_q <= 2'h0;
    end else if (at_c3) begin
      div0_q <= (div0_q == DIV_LAST) ? 2'h0 : div0_q + 2'h1;
      div1_q <= (div1_q == DIV_LAST) ? 2'h0 : div1_q + 2'h1;
    end
  end
  wire tick0 = turbo0 || div0_q == DIV_LAST; // R1
  wire tick1 = turbo1 || div1_q == DIV_LAST; // R1

  // Falling edge detection on count inputs, sampled at phase four
  logic samp0_q, samp1_q, edge0_q, edge1_q;
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      samp0_q <= 1'b0;
      samp1_q <= 1'b0;
      edge0_q <= 1'b0;
      edge1_q <= 1'b0;
    end else if (at_c4) begin
      samp0_q <= cnt0_s; // R3
      samp1_q <= cnt1_s; // R3
      edge0_q <= samp0_q && !cnt0_s; // R3
      edge1_q <= samp1_q && !cnt1_s; // R3
    end else if (at_c3) begin
      edge0_q <= 1'b0; // R4
      edge1_q <= 1'b0; // R4
    end
  end

  // Count enables; the increments inc0, inc0h and inc1 are qualified by phase three
  wire en0 = run0 && (!gate0 || external_interrupt0_pin_s); // R10 R14
  wire en1 = (split0 || run1) && (!gate1 || external_interrupt1_pin_s); // R10 R16
  wire inc0 = at_c3 && en0 && (func0 ? edge0_q : tick0); // R4
  wire inc0h = at_c3 && split0 && run1 && tick0; // R15
  wire inc1 = at_c3 && en1 && m1 != MODE_SPLIT && (func1 ? edge1_q : tick1); // R13
  wire [16:0] nx0 = bump(m0, th0_q, tl0_q);
  wire [16:0] nx1 = bump(m1, th1_q, tl1_q);
  wire ev0 = inc0 && nx0[16]; // R17
  wire ev0h = inc0h && th0_q == 8'hFF; // R15
  wire ev1 = split0 ? ev0h : (inc1 && nx1[16]); // R16

  assign tl0_d = wr_tl0 ? WDATA_I : inc0 ? nx0[7:0] : tl0_q; // R19
  assign th0_d = wr_th0 ? WDATA_I : split0 ? (inc0h ? th0_q + 8'h01 : th0_q) :
                 inc0 ? nx0[15:8] : th0_q; // R19
  assign tl1_d = wr_tl1 ? WDATA_I : inc1 ? nx1[7:0] : tl1_q; // R19
  assign th1_d = wr_th1 ? WDATA_I : inc1 ? nx1[15:8] : th1_q; // R19

  // Overflow flags: hardware set wins over vector or software clear
  assign ovf0_d = ev0 || (wr_ctrl ? WDATA_I[`TC_CTRL_FLAG0] : ovf0_q && !VECTOR0_I); // R17 R18
  assign ovf1_d = ev1 || (wr_ctrl ? WDATA_I[`TC_CTRL_FLAG1] : ovf1_q && !VECTOR1_I); // R17 R18
  assign stat_d = {ev1, ev0} | (stat_q & ~(wr_stat ? WDATA_I[1:0] : 2'h0));
  assign mask_d = wr_mask ? WDATA_I[1:0] : mask_q;

  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      mode_q <= `TC_RST_BYTE;
      ctrl_q <= `TC_RST_BYTE;
      clkctl_q <= `TC_RST_BYTE; // R2
      tl0_q <= `TC_RST_BYTE;
      th0_q <= `TC_RST_BYTE;
      tl1_q <= `TC_RST_BYTE;
      th1_q <= `TC_RST_BYTE;
      ovf0_q <= 1'b0;
      ovf1_q <= 1'b0;
      stat_q <= `TC_RST_IRQ;
      mask_q <= `TC_RST_IRQ;
      irq_q <= 1'b0;
    end else begin
      if (wr_mode) mode_q <= WDATA_I;
      if (wr_ctrl) ctrl_q <= WDATA_I & 8'h50;
      if (wr_clk) clkctl_q <= WDATA_I & 8'h18;
      tl0_q <= tl0_d;
      th0_q <= th0_d;
      tl1_q <= tl1_d;
      th1_q <= th1_d;
      ovf0_q <= ovf0_d;
      ovf1_q <= ovf1_d;
      stat_q <= stat_d;
      mask_q <= mask_d;
      irq_q <= |(stat_d & mask_d);
    end
  end

  // Read side: data stands only in the cycle after the strobe
  wire byte_t rd_mux =
    (ADDR_I == `TC_ADDR_MODE) ? mode_q :
    (ADDR_I == `TC_ADDR_CTRL) ? (ctrl_q | {ovf1_q, 1'b0, ovf0_q, 5'h00}) :
    (ADDR_I == `TC_ADDR_CLKCTL) ? clkctl_q :
    (ADDR_I == `TC_ADDR_C0LO) ? tl0_q :
    (ADDR_I == `TC_ADDR_C0HI) ? th0_q :
    (ADDR_I == `TC_ADDR_C1LO) ? tl1_q :
    (ADDR_I == `TC_ADDR_C1HI) ? th1_q :
    (ADDR_I == `TC_ADDR_ISTAT) ? {6'h00, stat_q} :
    (ADDR_I == `TC_ADDR_IMASK) ? {6'h00, mask_q} : 8'h00;

  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= RE_I ? rd_mux : 8'h00;
    end
  end

  assign RDATA_O = rdata_q;
  assign OVF0_O = ovf0_q;
  assign OVF1_O = ovf1_q;
  assign IRQ_O = irq_q;

  // Checks
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RESET_I);

  sequence fall0_s;
    at_c4 && samp0_q && !cnt0_s;
  endsequence

  sequence c3_quiet0_s;
    at_c3 && !WE_I;
  endsequence

  turbo_reset_a: assert property (@(posedge CLK_I) disable iff (1'b0) // R2
    RESET_I |=> !turbo0 && !turbo1)
    else $error("turbo select not cleared by reset");

  std_tick_a: assert property (c3_quiet0_s ##0 !turbo0 && !func0 && div0_q != DIV_LAST // R1
    |=> $stable(tl0_q))
    else $error("standard time base ticked early");

  edge_seen_a: assert property (fall0_s |=> edge0_q ##2 at_c3) // R3
    else $error("falling edge on count input missed");

  count_phase_a: assert property ($changed(tl0_q) |-> $past(at_c3) || $past(wr_tl0)) // R4
    else $error("counter 0 low byte changed off phase three");

  gate_hold_a: assert property (at_c3 && !run0 && !wr_tl0 |=> $stable(tl0_q)) // R10
    else $error("counter 0 counted while stopped");

  mode0_wrap_a: assert property (c3_quiet0_s ##0 m0 == MODE_13BIT && inc0 && // R9
    {th0_q, tl0_q[4:0]} == 13'h1FFF |=> th0_q == 8'h00 && tl0_q[4:0] == 5'h00 && ovf0_q)
    else $error("mode 0 wrap wrong");

  mode1_wrap_a: assert property (c3_quiet0_s ##0 m1 == MODE_16BIT && inc1 && // R11
    {th1_q, tl1_q} == 16'hFFFF && !split0 |=> {th1_q, tl1_q} == 16'h0000 && ovf1_q)
    else $error("mode 1 wrap wrong");

  reload_a: assert property (c3_quiet0_s ##0 m0 == MODE_RELOAD8 && inc0 && // R12
    tl0_q == 8'hFF |=> tl0_q == $past(th0_q) && th0_q == $past(th0_q) && ovf0_q)
    else $error("mode 2 reload wrong");

  freeze_a: assert property (m1 == MODE_SPLIT && !WE_I |=> $stable({th1_q, tl1_q})) // R13
    else $error("counter 1 moved in mode 3");

  split_high_a: assert property (c3_quiet0_s ##0 split0 && run1 && tick0 && // R15
    th0_q == 8'hFF |=> th0_q == 8'h00 && ovf1_q)
    else $error("split high byte wrap did not flag counter 1");

  vector_clear_a: assert property (VECTOR0_I && !ev0 && !wr_ctrl |=> !ovf0_q) // R18
    else $error("vector did not clear overflow flag");

  // Split mode phase-three slot, used by the split_run1_a check
  sequence split_c3_s;
    at_c3 && split0;
  endsequence

  vector1_clear_a: assert property (VECTOR1_I && !ev1 && !wr_ctrl |=> !ovf1_q) // R18
    else $error("vector did not clear counter 1 overflow flag");

  phase_step_a: assert property (!$past(RESET_I) |-> phase_q == $past(phase_q) + 2'h1)
    else $error("machine cycle phase skipped");

  turbo_tick_a: assert property (at_c3 && turbo0 && run0 && !gate0 && !func0 |-> inc0) // R1
    else $error("turbo time base missed a tick");

  func_select_a: assert property (at_c3 && func0 && !edge0_q |-> !inc0) // R6
    else $error("counter function counted without an edge");

  edge_count_a: assert property (at_c3 && func0 && edge0_q && run0 && !gate0 |-> inc0) // R4
    else $error("recognised edge not counted");

  edge_window_a: assert property (edge0_q |-> !at_c4) // R3
    else $error("stored edge survived into phase four");

  edge_hold_a: assert property (edge0_q && !at_c3 |=> edge0_q) // R3
    else $error("stored edge dropped before phase three");

  mode0_hold_a: assert property (c3_quiet0_s ##0 m0 == MODE_13BIT && inc0 && // R8
    tl0_q[4:0] != 5'h1F |=> $stable(th0_q) && tl0_q[7:5] == $past(tl0_q[7:5]))
    else $error("mode 0 touched ignored bits or high byte early");

  mode1_wrap0_a: assert property (c3_quiet0_s ##0 m0 == MODE_16BIT && inc0 && // R11
    {th0_q, tl0_q} == 16'hFFFF |=> {th0_q, tl0_q} == 16'h0000 && ovf0_q)
    else $error("counter 0 mode 1 wrap wrong");

  split_stop_a: assert property (c3_quiet0_s ##0 split0 && !run0 |=> $stable(tl0_q)) // R14
    else $error("split low byte ran without its run bit");

  split_run1_a: assert property (split_c3_s ##0 m1 != MODE_SPLIT && !gate1 && // R16
    turbo1 && !func1 |-> inc1)
    else $error("counter 1 did not run during split mode");

  split_flag1_a: assert property (split0 && !ev0h && !wr_ctrl && !VECTOR1_I && // R16
    !ovf1_q |=> !ovf1_q)
    else $error("counter 1 set its flag during split mode");

  flag_phase_a: assert property ($rose(ovf0_q) |-> $past(at_c3) || $past(wr_ctrl)) // R17
    else $error("overflow flag set off phase three");

  irq_level_a: assert property (IRQ_O == |(stat_q & mask_q))
    else $error("interrupt output disagrees with status and mask");

  read_idle_a: assert property (!$past(RE_I) |-> RDATA_O == 8'h00)
    else $error("read data shown without a read strobe");

endmodule // dual_timer
`default_nettype wire

// ### pin_model.sv
// Far-side model of the count and gate pins of both counters
`default_nettype none
module pin_model (
  input wire logic clk_i, // System clock
  output var logic cnt0_o, // Count input 0
  output var logic cnt1_o, // Count input 1
  output var logic gate0_o, // Gate pin 0
  output var logic gate1_o // Gate pin 1
);
  timeunit 1ns;
  timeprecision 1ps;
  initial {cnt0_o, cnt1_o, gate0_o, gate1_o} = 4'hF;
  // Low then high for 12 clocks each: one fall per 24 clocks
  task automatic pulses(input bit sel, input int n);
    repeat (n) begin
      for (int h = 0; h < 2; h++) begin
        if (sel) cnt1_o <= h[0];
        else cnt0_o <= h[0];
        repeat (12) @(posedge clk_i);
      end
    end
  endtask
  task automatic gate(input bit sel, input bit v);
    if (sel) gate1_o <= v;
    else gate0_o <= v;
  endtask
endmodule // pin_model
`default_nettype wire

// ### tb.sv
// Self-checking bench for the dual timer/counter
`default_nettype none
`include "tc_params.svh"
module tb import tc_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rst = 1'b1, we = 1'b0, re = 1'b0, vec0 = 1'b0, vec1 = 1'b0;
  logic [3:0] addr = 4'h0;
  byte_t wdata = 8'h00, rdata;
  logic ovf0, ovf1, irq, cnt0, cnt1, g0, g1, rd_pend = 1'b0;
  int n_fail = 0, n_tests = 0, cyc = 0, guard = 0;
  logic [31:0] seed = 32'hBF57;
  byte_t expq[$];
  initial forever #4 clk = ~clk;
  dual_timer #(.STD_DIV(`TC_STD_TICK_CLKS)) dual_timer_inst (
    .CLK_I(clk), .RESET_I(rst), .ADDR_I(addr), .WDATA_I(wdata), .WE_I(we),
    .RE_I(re), .CNT0_PIN_I(cnt0), .CNT1_PIN_I(cnt1), .EXT_EXTERNAL_INTERRUPT0_PIN_PIN_I(g0),
    .EXT_EXTERNAL_INTERRUPT1_PIN_PIN_I(g1), .VECTOR0_I(vec0), .VECTOR1_I(vec1),
    .RDATA_O(rdata), .OVF0_O(ovf0), .OVF1_O(ovf1), .IRQ_O(irq));
  pin_model pin_model_inst (.clk_i(clk), .cnt0_o(cnt0), .cnt1_o(cnt1),
    .gate0_o(g0), .gate1_o(g1));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic tally_and_finish();
    if (n_fail == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic tick(input int n = 1);
    repeat (n) begin
      @(posedge clk);
      cyc++;
    end
  endtask
  // Strobes land on edges clear of the count update edges
  task automatic acc(input logic w, input logic [3:0] a, input byte_t d);
    tick();
    while (cyc % 4 != 2) tick();
    addr <= a;
    wdata <= d;
    if (w) we <= 1'b1;
    else re <= 1'b1;
    tick();
    we <= 1'b0;
    re <= 1'b0;
  endtask
  task automatic wr(input logic [3:0] a, input byte_t d);
    acc(1'b1, a, d);
  endtask
  task automatic rd(input logic [3:0] a, input byte_t e);
    expq.push_back(e);
    acc(1'b0, a, e);
  endtask
  task automatic prog(input byte_t md, ck, hi, lo, ct);
    wr(`TC_ADDR_CTRL, 8'h00);
    wr(`TC_ADDR_MODE, md);
    wr(`TC_ADDR_CLKCTL, ck);
    wr(`TC_ADDR_C0HI, hi);
    wr(`TC_ADDR_C0LO, lo);
    wr(`TC_ADDR_CTRL, ct);
  endtask
  task automatic chkf(input logic [2:0] e);
    #1;
    n_tests++;
    if ({ovf0, ovf1, irq} !== e) begin
      n_fail++;
      $display("FAIL flags exp %b got %b", e, {ovf0, ovf1, irq});
    end
  endtask
  task automatic cmp_byte(input byte_t e, input byte_t g);
    n_tests++;
    if (g !== e) begin
      n_fail++;
      $display("FAIL rdata exp %h got %h", e, g);
    end
  endtask
  always @(posedge clk) begin
    if (rd_pend) cmp_byte(expq.pop_front(), rdata);
    rd_pend <= re;
    guard <= guard + 1;
    if (guard == 20000) begin
      n_fail++;
      tally_and_finish();
    end
  end
  initial begin
    tick(6);
    rst <= 1'b0;
    rd(`TC_ADDR_MODE, 8'h00);
    rd(`TC_ADDR_CLKCTL, 8'h00);
    rd(`TC_ADDR_C0LO, 8'h00);
    rd(4'hF, 8'h00);
    wr(`TC_ADDR_IMASK, 8'h01);
    prog(8'h01, 8'h08, 8'hFF, 8'hFC, 8'h10);
    rd(`TC_ADDR_C0LO, 8'hFD);
    rd(`TC_ADDR_C0LO, 8'hFE);
    rd(`TC_ADDR_C0LO, 8'hFF);
    rd(`TC_ADDR_C0HI, 8'h00);
    chkf(3'b101);
    rd(`TC_ADDR_ISTAT, 8'h01);
    rd(`TC_ADDR_CTRL, 8'h30);
    tick();
    vec0 <= 1'b1;
    tick();
    vec0 <= 1'b0;
    chkf(3'b001);
    wr(`TC_ADDR_ISTAT, 8'h01);
    chkf(3'b000);
    prog(8'h01, 8'h00, 8'h00, 8'h00, 8'h10);
    tick(44);
    rd(`TC_ADDR_C0LO, 8'h04);
    prog(8'h00, 8'h08, 8'hFF, 8'h1E, 8'h10);
    rd(`TC_ADDR_C0LO, 8'h1F);
    rd(`TC_ADDR_C0HI, 8'h00);
    chkf(3'b101);
    prog(8'h02, 8'h08, 8'h80, 8'hFE, 8'h10);
    rd(`TC_ADDR_C0LO, 8'hFF);
    rd(`TC_ADDR_C0LO, 8'h80);
    rd(`TC_ADDR_C0HI, 8'h80);
    pin_model_inst.gate(1'b0, 1'b0);
    prog(8'h09, 8'h08, 8'h00, 8'h00, 8'h10);
    tick(4);
    rd(`TC_ADDR_C0LO, 8'h00);
    pin_model_inst.gate(1'b0, 1'b1);
    tick(8);
    wr(`TC_ADDR_C0LO, 8'h00);
    rd(`TC_ADDR_C0LO, 8'h01);
    prog(8'h05, 8'h00, 8'h00, 8'h00, 8'h10);
    fork
      pin_model_inst.pulses(1'b0, 3);
      tick(72);
    join
    tick(12);
    rd(`TC_ADDR_C0LO, 8'h03);
    wr(`TC_ADDR_MODE, 8'h50);
    wr(`TC_ADDR_C1LO, 8'h00);
    wr(`TC_ADDR_CTRL, 8'h40);
    fork
      pin_model_inst.pulses(1'b1, 2);
      tick(48);
    join
    tick(12);
    rd(`TC_ADDR_C1LO, 8'h02);
    wr(`TC_ADDR_ISTAT, 8'h03);
    wr(`TC_ADDR_C1LO, 8'h10);
    prog(8'h33, 8'h18, 8'hFE, 8'h00, 8'h40);
    rd(`TC_ADDR_C0HI, 8'hFF);
    rd(`TC_ADDR_C0HI, 8'h00);
    rd(`TC_ADDR_C1LO, 8'h10);
    chkf(3'b010);
    wr(`TC_ADDR_IMASK, 8'h02);
    chkf(3'b011);
    tick();
    vec1 <= 1'b1;
    tick();
    vec1 <= 1'b0;
    chkf(3'b001);
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      wr(`TC_ADDR_C1HI, seed[7:0]);
      rd(`TC_ADDR_C1HI, seed[7:0]);
    end
    wr(`TC_ADDR_MODE, 8'h13);
    wr(`TC_ADDR_CTRL, 8'h00);
    wr(`TC_ADDR_C1LO, 8'h10);
    rd(`TC_ADDR_C1LO, 8'h11);
    wr(`TC_ADDR_MODE, 8'h11);
    wr(`TC_ADDR_CTRL, 8'h40);
    wr(`TC_ADDR_C1HI, 8'hFF);
    wr(`TC_ADDR_C1LO, 8'hFF);
    rd(`TC_ADDR_C1LO, 8'h00);
    rd(`TC_ADDR_C1HI, 8'h00);
    chkf(3'b011);
    tick(4);
    tally_and_finish();
  end
endmodule // tb
`default_nettype wire
